// ### common/sslb_pkg.sv
package sslb_pkg;

    // Word framing
    localparam int WORD_BITS = 24;
    localparam logic [1:0] DEST_CONTROL = 2'h0;
    localparam logic [1:0] DEST_REFERENCE = 2'h1;
    localparam logic [1:0] DEST_FEEDBACK = 2'h2;

    // Divider and lock figures
    localparam int FB_DIV_BITS = 13;
    localparam int REF_DIV_BITS = 14;
    localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
    localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
    localparam logic [1:0] SYNC_PD_EDGES = 2'h2;

    // Output multiplexer selections
    localparam logic [2:0] MUX_LOW = 3'h0;
    localparam logic [2:0] MUX_LOCK = 3'h1;
    localparam logic [2:0] MUX_FB_DIV = 3'h2;
    localparam logic [2:0] MUX_HIGH = 3'h3;
    localparam logic [2:0] MUX_REF_DIV = 3'h4;
    localparam logic [2:0] MUX_BAND_CLK = 3'h5;

    // Field layouts, msb first
    typedef struct packed {
        logic [1:0] spare;
        logic powerdown_sync_mode;
        logic powerdown_request;
        logic [2:0] pump_current_two;
        logic [2:0] pump_current_one;
        logic [1:0] out_power;
        logic mute_till_lock;
        logic pump_gain;
        logic pump_tristate;
        logic detector_polarity;
        logic [2:0] outmux_sel;
        logic counter_reset;
        logic [1:0] core_power;
        logic [1:0] dest;
    } sslb_ctrl_type;

    typedef struct packed {
        logic [1:0] spare;
        logic pump_gain;
        logic [FB_DIV_BITS-1:0] feedback_div;
        logic [5:0] reserved;
        logic [1:0] dest;
    } sslb_fb_type;

    typedef struct packed {
        logic [1:0] reserved;
        logic [1:0] band_clk_div;
        logic factory_test_bit;
        logic lock_precision;
        logic [1:0] antibacklash;
        logic [REF_DIV_BITS-1:0] ref_div;
        logic [1:0] dest;
    } sslb_ref_type;

    // Values after reset
    localparam logic [23:0] CTRL_RESET = 24'h000000;
    localparam logic [23:0] FB_RESET = 24'h000302;
    localparam logic [23:0] REF_RESET = 24'h000005;

endpackage

// ### verilog/sslb_shifter.sv
`timescale 1ns/1ns
module sslb_shifter #(
    parameter int BITS = 24
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Raw pins
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic load_enable_i,
    // Word out
    output logic [BITS-1:0] word_o,
    output logic load_o
);

    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic [1:0] le_sync;
    logic clk_prev;
    logic le_prev;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clk_sync <= 2'h0;
            data_sync <= 2'h0;
            // Load enable idles high: no false load after reset
            le_sync <= 2'h3;
            clk_prev <= 1'b0;
            le_prev <= 1'b1;
        end else begin
            clk_sync <= {clk_sync[0], sclk_i};
            data_sync <= {data_sync[0], sdata_i};
            le_sync <= {le_sync[0], load_enable_i};
            clk_prev <= clk_sync[1];
            le_prev <= le_sync[1];
        end
    end

    // Shift keeps running in every power state
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_o <= '0;
        end else if (clk_sync[1] && !clk_prev) begin
            word_o <= {word_o[BITS-2:0], data_sync[1]};
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_o <= 1'b0;
        end else begin
            load_o <= le_sync[1] && !le_prev;
        end
    end

endmodule

// ### verilog/sslb_divider.sv
`timescale 1ns/1ns
module sslb_divider #(
    parameter int WIDTH = 14
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Control
    input wire logic hold_i,
    input wire logic tick_i,
    input wire logic [WIDTH-1:0] ratio_i,
    // Divided pulse
    output logic pulse_o
);

    logic [WIDTH-1:0] count;

    // Held at load state: count restarts at one
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= WIDTH'(1);
            pulse_o <= 1'b0;
        end else if (hold_i) begin
            count <= WIDTH'(1);
            pulse_o <= 1'b0;
        end else if (tick_i) begin
            pulse_o <= count >= ratio_i;
            count <= (count >= ratio_i) ? WIDTH'(1) : count + WIDTH'(1);
        end else begin
            pulse_o <= 1'b0;
        end
    end

endmodule

// ### verilog/sslb_latch_bank.sv
`timescale 1ns/1ns
module sslb_latch_bank (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Serial link pins
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic load_enable_i,
    // Device pins
    input wire logic chip_enable_i,
    input wire logic ref_in_i,
    input wire logic fb_in_i,
    input wire logic phase_ok_i,
    // Loop controls
    output logic powered_down_o,
    output logic ref_buffer_en_o,
    output logic rf_out_en_o,
    output logic pump_tristate_o,
    output logic [2:0] pump_current_o,
    output logic detector_polarity_o,
    output logic [1:0] antibacklash_o,
    output logic [1:0] out_power_o,
    output logic [1:0] core_power_o,
    output logic test_mode_o,
    output logic lock_o,
    output logic band_clk_o,
    // Multiplexer pin
    output logic outmux_pin_o,
    output logic outmux_oe_o
);

    sslb_pkg::sslb_ctrl_type ctrl;
    sslb_pkg::sslb_fb_type fb;
    sslb_pkg::sslb_ref_type refw;
    logic [23:0] word;
    logic load;
    logic pump_gain;
    logic [1:0] ce_sync;
    logic [1:0] ref_sync;
    logic [1:0] fb_sync;
    logic [1:0] ok_sync;
    logic ref_prev;
    logic fb_prev;
    logic soft_pd;
    logic sync_armed;
    logic [1:0] sync_edges;
    logic hold_counters;
    logic ref_pulse;
    logic fb_pulse;
    logic [2:0] good_cycles;
    logic locked;
    logic [2:0] band_count;
    logic band_pulse;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Serial word capture
    sslb_shifter #(
        .BITS(sslb_pkg::WORD_BITS)
    ) u_shifter (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .sclk_i(sclk_i),
        .sdata_i(sdata_i),
        .load_enable_i(load_enable_i),
        .word_o(word),
        .load_o(load)
    );

    function automatic logic dest_is(input logic [23:0] w, input logic [1:0] code);
        dest_is = w[1:0] == code;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Latches
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl <= sslb_pkg::CTRL_RESET;
        end else if (load && dest_is(word, sslb_pkg::DEST_CONTROL)) begin
            ctrl <= word;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            refw <= sslb_pkg::REF_RESET;
        end else if (load && dest_is(word, sslb_pkg::DEST_REFERENCE)) begin
            refw <= word;
        end
    end

    // Reserved bits are stored but steer nothing
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fb <= sslb_pkg::FB_RESET;
        end else if (load && dest_is(word, sslb_pkg::DEST_FEEDBACK)) begin
            fb <= word;
        end
    end

    // Shared gain bit follows the most recent writer
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pump_gain <= 1'b0;
        end else if (load && dest_is(word, sslb_pkg::DEST_CONTROL)) begin
            pump_gain <= word[10];
        end else if (load && dest_is(word, sslb_pkg::DEST_FEEDBACK)) begin
            pump_gain <= word[21];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ce_sync <= 2'h0;
            ref_sync <= 2'h0;
            fb_sync <= 2'h0;
            ok_sync <= 2'h0;
            ref_prev <= 1'b0;
            fb_prev <= 1'b0;
        end else begin
            ce_sync <= {ce_sync[0], chip_enable_i};
            ref_sync <= {ref_sync[0], ref_in_i};
            fb_sync <= {fb_sync[0], fb_in_i};
            ok_sync <= {ok_sync[0], phase_ok_i};
            ref_prev <= ref_sync[1];
            fb_prev <= fb_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Software power-down
    // Sync mode waits on divider edges so the pump is not cut mid-correction
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_pd <= 1'b0;
            sync_armed <= 1'b0;
            sync_edges <= 2'h0;
        end else if (load && dest_is(word, sslb_pkg::DEST_CONTROL)) begin
            sync_edges <= 2'h0;
            if (!word[20]) begin
                soft_pd <= 1'b0;
                sync_armed <= 1'b0;
            end else if (!word[21]) begin
                soft_pd <= 1'b1;
                sync_armed <= 1'b0;
            end else begin
                sync_armed <= !soft_pd;
            end
        end else if (sync_armed && ref_pulse) begin
            if (sync_edges == sslb_pkg::SYNC_PD_EDGES - 2'h1) begin
                soft_pd <= 1'b1;
                sync_armed <= 1'b0;
            end
            sync_edges <= sync_edges + 2'h1;
        end
    end

    // Dividers keep counting while a sync power-down is pending
    assign hold_counters = soft_pd || !ce_sync[1] || ctrl.counter_reset;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reference and feedback dividers
    sslb_divider #(
        .WIDTH(sslb_pkg::REF_DIV_BITS)
    ) u_ref_div (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .hold_i(hold_counters),
        .tick_i(ref_sync[1] && !ref_prev),
        .ratio_i(refw.ref_div),
        .pulse_o(ref_pulse)
    );

    sslb_divider #(
        .WIDTH(sslb_pkg::FB_DIV_BITS)
    ) u_fb_div (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .hold_i(hold_counters),
        .tick_i(fb_sync[1] && !fb_prev),
        .ratio_i(fb.feedback_div),
        .pulse_o(fb_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Lock detect
    // Phase window flag is judged outside; only its consecutive count lives here
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            good_cycles <= 3'h0;
            locked <= 1'b0;
        end else if (hold_counters) begin
            good_cycles <= 3'h0;
            locked <= 1'b0;
        end else if (ref_pulse) begin
            if (!ok_sync[1]) begin
                good_cycles <= 3'h0;
                locked <= 1'b0;
            end else if (good_cycles + 3'h1 >= (refw.lock_precision ? sslb_pkg::LOCK_CYCLES_FINE
                                                                 : sslb_pkg::LOCK_CYCLES_COARSE)) begin
                locked <= 1'b1;
            end else begin
                good_cycles <= good_cycles + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Band select clock
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            band_count <= 3'h0;
            band_pulse <= 1'b0;
        end else if (hold_counters) begin
            band_count <= 3'h0;
            band_pulse <= 1'b0;
        end else if (ref_pulse) begin
            band_pulse <= (band_count & ((3'h1 << refw.band_clk_div) - 3'h1)) == 3'h0;
            band_count <= band_count + 3'h1;
        end else begin
            band_pulse <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            powered_down_o <= 1'b1;
            ref_buffer_en_o <= 1'b0;
            rf_out_en_o <= 1'b0;
            pump_tristate_o <= 1'b1;
            pump_current_o <= 3'h0;
            detector_polarity_o <= 1'b0;
            antibacklash_o <= 2'h0;
            out_power_o <= 2'h0;
            core_power_o <= 2'h0;
            test_mode_o <= 1'b0;
            lock_o <= 1'b0;
            band_clk_o <= 1'b0;
        end else begin
            powered_down_o <= soft_pd || !ce_sync[1];
            ref_buffer_en_o <= !(soft_pd || !ce_sync[1]);
            rf_out_en_o <= !(soft_pd || !ce_sync[1]) && (!ctrl.mute_till_lock || locked);
            pump_tristate_o <= soft_pd || !ce_sync[1] || ctrl.pump_tristate;
            pump_current_o <= pump_gain ? ctrl.pump_current_two : ctrl.pump_current_one;
            detector_polarity_o <= ctrl.detector_polarity;
            antibacklash_o <= refw.antibacklash;
            out_power_o <= ctrl.out_power;
            core_power_o <= ctrl.core_power;
            test_mode_o <= refw.factory_test_bit;
            lock_o <= locked;
            band_clk_o <= band_pulse;
        end
    end

    // Pin floats while powered down
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            outmux_pin_o <= 1'b0;
            outmux_oe_o <= 1'b0;
        end else begin
            outmux_oe_o <= !(soft_pd || !ce_sync[1]);
            unique case (ctrl.outmux_sel)
                sslb_pkg::MUX_LOCK: outmux_pin_o <= locked;
                sslb_pkg::MUX_FB_DIV: outmux_pin_o <= fb_pulse;
                sslb_pkg::MUX_HIGH: outmux_pin_o <= 1'b1;
                sslb_pkg::MUX_REF_DIV: outmux_pin_o <= ref_pulse;
                sslb_pkg::MUX_BAND_CLK: outmux_pin_o <= band_pulse;
                default: outmux_pin_o <= 1'b0;
            endcase
        end
    end

endmodule

// ### dv/sslb_latch_bank_assertions.sv
`timescale 1ns/1ns
module sslb_latch_bank_assertions (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Watched pins
    input wire logic chip_enable_i,
    input wire logic powered_down_o,
    input wire logic ref_buffer_en_o,
    input wire logic rf_out_en_o,
    input wire logic pump_tristate_o,
    input wire logic lock_o,
    input wire logic band_clk_o,
    input wire logic outmux_oe_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////
    // One cycle of slack: outputs may trail the down flag
    sequence s_down;
        powered_down_o ##1 powered_down_o;
    endsequence
    sequence s_ce_low;
        !chip_enable_i [*4];
    endsequence
    AST_CE_DOWN: assert property (s_ce_low |-> powered_down_o)
        else $error("chip enable low but not down");
    AST_PD_QUIET: assert property (s_down |-> !(ref_buffer_en_o || rf_out_en_o || outmux_oe_o))
        else $error("outputs active while down");
    AST_PD_PUMP: assert property (s_down |-> pump_tristate_o)
        else $error("pump driving while down");
    AST_PD_LOCK: assert property (s_down |-> !lock_o)
        else $error("lock held while down");
    AST_PD_BAND: assert property (powered_down_o [*3] |-> !band_clk_o)
        else $error("band clock ticking while down");
    AST_BAND_PULSE: assert property (band_clk_o |=> !band_clk_o)
        else $error("band clock pulse too long");
    AST_RF_BUF: assert property (rf_out_en_o |-> ref_buffer_en_o)
        else $error("outputs on with buffer off");
    AST_WAKE: assert property ($fell(powered_down_o) |-> ##[0:1] ref_buffer_en_o)
        else $error("buffer stayed off after wake");
endmodule

bind sslb_latch_bank sslb_latch_bank_assertions chk (.mclk_i, .resetn_i, .chip_enable_i, .powered_down_o,
    .ref_buffer_en_o, .rf_out_en_o, .pump_tristate_o, .lock_o, .band_clk_o, .outmux_oe_o);

// ### dv/sslb_host_model.sv
`timescale 1ns/1ns
module sslb_host_model (
    // Clock
    input wire logic mclk_i,
    // Three-wire link
    output logic sclk_o,
    output logic sdata_o,
    output logic load_enable_o
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        load_enable_o = 1'b1;
    end
    // Msb first, 320 ns per bit; clock stands low between frames
    task automatic send(input logic [23:0] w);
        @(negedge mclk_i);
        load_enable_o = 1'b0;
        repeat (3) @(negedge mclk_i);
        for (int i = 23; i >= 0; i--) begin
            sdata_o = w[i];
            repeat (4) @(negedge mclk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge mclk_i);
            sclk_o = 1'b0;
        end
        // No pull on data: show a stale inverse once released
        sdata_o = ~sdata_o;
        repeat (4) @(negedge mclk_i);
        load_enable_o = 1'b1;
    endtask
endmodule

// ### dv/sslb_latch_bank_tb.sv
`timescale 1ns/1ns
module sslb_latch_bank_tb;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic chip_enable_i = 1'b1;
    logic ref_in_i = 1'b0;
    logic fb_in_i = 1'b0;
    logic phase_ok_i = 1'b0;
    logic sclk_i, sdata_i, load_enable_i, powered_down_o, ref_buffer_en_o, rf_out_en_o, pump_tristate_o;
    logic detector_polarity_o, test_mode_o, lock_o, band_clk_o, outmux_pin_o, outmux_oe_o;
    logic [2:0] pump_current_o;
    logic [1:0] antibacklash_o, out_power_o, core_power_o;
    logic [3:0] ph = 4'h0;
    int fail_count = 0;
    int cmp_count = 0;
    int nr, nb;
    sslb_pkg::sslb_ctrl_type c;
    sslb_pkg::sslb_ref_type r;
    sslb_pkg::sslb_fb_type f;

    always #20 mclk_i = ~mclk_i;
    // Reference 320 ns, feedback 160 ns, free running
    always @(negedge mclk_i) begin
        ph <= ph + 4'h1;
        ref_in_i <= ph[2];
        fb_in_i <= ph[1];
    end

    sslb_latch_bank DUT (.mclk_i, .resetn_i, .sclk_i, .sdata_i, .load_enable_i, .chip_enable_i, .ref_in_i,
        .fb_in_i, .phase_ok_i, .powered_down_o, .ref_buffer_en_o, .rf_out_en_o, .pump_tristate_o,
        .pump_current_o, .detector_polarity_o, .antibacklash_o, .out_power_o, .core_power_o, .test_mode_o,
        .lock_o, .band_clk_o, .outmux_pin_o, .outmux_oe_o);
    sslb_host_model host (.mclk_i, .sclk_o(sclk_i), .sdata_o(sdata_i), .load_enable_o(load_enable_i));

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic put(input logic [23:0] w);
        host.send(w);
        repeat (8) @(negedge mclk_i);
    endtask

    // Counts reference pulses on the mux pin until down or locked
    task automatic pulses_until(input bit on_lock, output int n);
        logic prev;
        n = 0;
        prev = outmux_pin_o;
        for (int k = 0; k < 400 && (on_lock ? lock_o : powered_down_o) !== 1'b1; k++) begin
            @(negedge mclk_i);
            n += (outmux_pin_o === 1'b1 && prev !== 1'b1) ? 1 : 0;
            prev = outmux_pin_o;
        end
    endtask

    task automatic count_window(input int cyc, output int a, output int b);
        a = 0;
        b = 0;
        repeat (cyc) begin
            @(negedge mclk_i);
            a += (outmux_pin_o === 1'b1) ? 1 : 0;
            b += (band_clk_o === 1'b1) ? 1 : 0;
        end
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        c.pump_current_one = 3'h5;
        c.pump_current_two = 3'h2;
        c.out_power = 2'h2;
        c.core_power = 2'h1;
        c.detector_polarity = 1'b1;
        put(c);
        check(pump_current_o, 3'h5, "current one");
        check({out_power_o, core_power_o}, 4'h9, "power levels");
        check(detector_polarity_o, 1'b1, "polarity");
        c.pump_gain = 1'b1;
        c.pump_tristate = 1'b1;
        c.detector_polarity = 1'b0;
        put(c);
        check(pump_current_o, 3'h2, "current two");
        check({pump_tristate_o, detector_polarity_o}, 2'h2, "pump off");
        put(f);
        check(pump_current_o, 3'h5, "gain by feedback");
        c.pump_tristate = 1'b0;
        put(c);
        check({pump_tristate_o, pump_current_o}, 4'h2, "gain by control");
        c.outmux_sel = sslb_pkg::MUX_HIGH;
        put(c);
        check(outmux_pin_o, 1'b1, "mux high");
        c.outmux_sel = sslb_pkg::MUX_FB_DIV;
        put(c);
        // Feedback ratio 3 on a 4-cycle input: one pulse every 12 cycles
        count_window(120, nr, nb);
        check(nr, 10, "mux feedback pulses");
        c.outmux_sel = sslb_pkg::MUX_LOW;
        put(c);
        check(outmux_pin_o, 1'b0, "mux low");
    endtask

    task automatic t_ref;
        r.antibacklash = 2'h3;
        r.factory_test_bit = 1'b1;
        put(r);
        check({antibacklash_o, test_mode_o}, 3'h7, "reference fields");
        put({r[23:18], 2'h1, r[15:2], 2'h3});
        check(antibacklash_o, 2'h3, "dest 11 ignored");
        r.factory_test_bit = 1'b0;
        put(r);
        check(test_mode_o, 1'b0, "test bit");
    endtask

    task automatic t_powerdown;
        c.powerdown_request = 1'b1;
        put(c);
        check(powered_down_o, 1'b1, "async down");
        check({ref_buffer_en_o, outmux_oe_o, pump_tristate_o}, 3'h1, "down outputs");
        r.antibacklash = 2'h2;
        put(r);
        check(antibacklash_o, 2'h2, "load while down");
        c.powerdown_request = 1'b0;
        put(c);
        check(powered_down_o, 1'b0, "back up");
        c.outmux_sel = sslb_pkg::MUX_REF_DIV;
        c.powerdown_sync_mode = 1'b1;
        c.powerdown_request = 1'b1;
        host.send(c);
        pulses_until(1'b0, nr);
        check(nr, 2, "pulses before sync down");
        c.powerdown_request = 1'b0;
        c.powerdown_sync_mode = 1'b0;
        put(c);
        chip_enable_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        check({powered_down_o, ref_buffer_en_o}, 2'h2, "hardware down");
        chip_enable_i = 1'b1;
        repeat (6) @(negedge mclk_i);
        check(powered_down_o, 1'b0, "hardware up");
    endtask

    task automatic t_lock;
        c.mute_till_lock = 1'b1;
        for (int p = 0; p < 2; p++) begin
            r.lock_precision = p[0];
            put(r);
            put(c);
            check(rf_out_en_o, 1'b0, "muted");
            for (int k = 0; k < 100 && outmux_pin_o !== 1'b1; k++)
                @(negedge mclk_i);
            @(negedge mclk_i);
            phase_ok_i = 1'b1;
            pulses_until(1'b1, nr);
            check(nr, p ? 5 : 3, "good cycles to lock");
            repeat (2) @(negedge mclk_i);
            check(rf_out_en_o, 1'b1, "unmuted");
            phase_ok_i = 1'b0;
            repeat (48) @(negedge mclk_i);
            check(lock_o, 1'b0, "bad cycle drops lock");
        end
        c.counter_reset = 1'b1;
        put(c);
        phase_ok_i = 1'b1;
        count_window(100, nr, nb);
        check({nr[7:0], lock_o}, 9'h0, "counters held");
        phase_ok_i = 1'b0;
        c.counter_reset = 1'b0;
        c.mute_till_lock = 1'b0;
        put(c);
    endtask

    task automatic t_band;
        for (int d = 0; d < 4; d++) begin
            r.band_clk_div = d[1:0];
            put(r);
            count_window(660, nr, nb);
            check((nb << d) <= nr + (1 << d) && (nb << d) + (1 << d) >= nr, 1'b1, "band ratio");
        end
    endtask

    initial begin
        c = '0;
        r = '0;
        f = '0;
        c.dest = sslb_pkg::DEST_CONTROL;
        r.dest = sslb_pkg::DEST_REFERENCE;
        r.ref_div = 14'h0004;
        f.dest = sslb_pkg::DEST_FEEDBACK;
        f.feedback_div = 13'h0003;
        repeat (20) @(negedge mclk_i);
        resetn_i = 1'b1;
        put(r);
        put(c);
        repeat (100) @(negedge mclk_i);
        put(f);
        check(powered_down_o, 1'b0, "powered up");
        t_regs();
        t_ref();
        t_powerdown();
        t_lock();
        t_band();
        give_verdict();
    end

    initial begin
        repeat (40000) @(negedge mclk_i);
        fail_count++;
        give_verdict();
    end
endmodule
